// ===== common/pwr_seq_pkg.sv
// Constants for the module power sequencer
package pwr_seq_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned TICK_NS         = 1_000_000;
  localparam int unsigned CLK_NS          = 100;
  localparam int unsigned TICK_CYCLES     = TICK_NS / CLK_NS;
  localparam int unsigned TICK_W          = 14;
  localparam int unsigned SELFTEST_MS     = 1600;
  localparam int unsigned INPUT_HOLD_MS   = 100;
  localparam int unsigned KEY_ON_MIN_MS   = 500;
  localparam int unsigned KEY_ON_MAX_MS   = 1500;
  localparam int unsigned KEY_OFF_MS      = 2000;
  localparam int unsigned IGN_GUARD_MS    = 30000;
  localparam int unsigned SHUTDOWN_MS     = 10;
  localparam int unsigned MS_W            = 16;
  localparam logic [MS_W-1:0] MS_ZERO     = 16'h0000;

  typedef enum logic [2:0] {
    ST_OFF      = 3'b000,
    ST_SELFTEST = 3'b001,
    ST_ON       = 3'b011,
    ST_SHUTDOWN = 3'b010
  } pwr_state_t;

  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_KEY  = 2'b01,
    SRC_IGN  = 2'b10
  } on_src_t;
endpackage

// ===== design/ms_tick_gen.sv
// Millisecond tick divider
`timescale 1ns/1ns
module ms_tick_gen #(
  // Clock cycles per tick
  parameter int unsigned TICK_DIV = pwr_seq_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Tick
  output logic      tick
);
  import pwr_seq_pkg::*;

  logic [TICK_W-1:0] cnt_reg;
  logic [TICK_W-1:0] cnt_next;
  logic              tick_reg;
  logic              tick_next;

  always_comb begin
    tick_next = 1'b0;
    cnt_next  = cnt_reg + 14'h0001;
    if (cnt_reg == TICK_W'(TICK_DIV - 1)) begin
      cnt_next  = 14'h0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg  <= 14'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule

// ===== design/power_sequencer.sv
// Power-on and power-off sequencer for the modem module
//
// Overview of operation
// - Powered-off indicator low off, high on
// - UART1 clear-to-send high until ready
// - UART2 clear-to-send follows same convention
// - Every turn-on runs 1600 ms self-test
// - Off state keeps only timer running
// - Supply rise starts power-on automatically
// - No request: power off after self-test
// - Key or ignition in self-test completes power-up; code ignores both until supply has been held 100 ms
// - Key low 500-1500 ms turns on
// - Key beyond 1.5 s may power off
// - Ignition high turns device on
// - Ignition low powers device down
// - Key low 2 s starts power-off
// - Ignition-off only if ignition powered on
// - Ignition-off ignored first 30 s
`timescale 1ns/1ns
module power_sequencer #(
  // Clock cycles per millisecond tick
  parameter int unsigned TICK_DIV = pwr_seq_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Supply and host controls
  input  wire logic supply_good,
  input  wire logic power_key_n,
  input  wire logic ignition_in,
  // Status outputs
  output logic      powered_off_n,
  output logic      uart1_clear_to_send_n,
  output logic      uart2_clear_to_send_n,
  output logic      rtc_only
);
  import pwr_seq_pkg::*;

  // ----------------------------------------
  // Tick and input synchronisers
  // ----------------------------------------
  logic tick;

  ms_tick_gen #(
    .TICK_DIV (TICK_DIV)
  ) u_tick (
    .clk   (clk),
    .reset (reset),
    .tick  (tick)
  );

  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync1_next;

  always_comb begin
    sync1_next = {supply_good, ~power_key_n, ignition_in};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync1_reg;
    end
  end

  logic sup_s;
  logic key_s;
  logic ign_s;
  assign sup_s = sync2_reg[2];
  assign key_s = sync2_reg[1];
  assign ign_s = sync2_reg[0];

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  pwr_state_t       state_reg, state_next;
  on_src_t          src_reg, src_next;
  logic [MS_W-1:0]  st_ms_reg, st_ms_next;
  logic [MS_W-1:0]  on_ms_reg, on_ms_next;
  logic [MS_W-1:0]  sup_ms_reg, sup_ms_next;
  logic [MS_W-1:0]  key_ms_reg, key_ms_next;
  logic             sup_prev_reg, sup_prev_next;
  logic             ign_prev_reg, ign_prev_next;
  logic             key_prev_reg, key_prev_next;
  logic             pend_reg, pend_next;
  logic             key_ok_reg, key_ok_next;
  logic             off_n_next;
  logic             cts_next;
  logic             rtc_next;

  function automatic logic [MS_W-1:0] sat_inc(input logic [MS_W-1:0] v, input logic t);
    sat_inc = (t && v != 16'hFFFF) ? v + 16'h0001 : v;
  endfunction

  logic inputs_live;
  logic key_release;
  logic key_on_pulse;
  logic ign_rise;
  assign inputs_live  = sup_ms_reg >= MS_W'(INPUT_HOLD_MS);
  assign key_release  = key_prev_reg && !key_s;
  assign key_on_pulse = key_release && key_ms_reg >= MS_W'(KEY_ON_MIN_MS)
                        && key_ms_reg <= MS_W'(KEY_ON_MAX_MS);
  assign ign_rise     = ign_s && !ign_prev_reg;

  always_comb begin
    state_next    = state_reg;
    src_next      = src_reg;
    st_ms_next    = st_ms_reg;
    on_ms_next    = sat_inc(on_ms_reg, tick);
    sup_ms_next   = sup_s ? sat_inc(sup_ms_reg, tick) : MS_ZERO;
    key_ms_next   = key_s ? sat_inc(key_ms_reg, tick) : MS_ZERO;
    sup_prev_next = sup_s;
    ign_prev_next = ign_s;
    key_prev_next = key_s;
    pend_next     = pend_reg;
    key_ok_next   = key_ok_reg;
    if (!key_s)
      key_ok_next = 1'b1;
    if (!inputs_live)
      key_ms_next = MS_ZERO;
    case (state_reg)
      ST_OFF: begin
        pend_next = 1'b0;
        if (sup_s && !sup_prev_reg) begin
          state_next = ST_SELFTEST;
          src_next   = SRC_NONE;
          st_ms_next = MS_ZERO;
        end else if (inputs_live && key_on_pulse) begin
          state_next = ST_SELFTEST;
          src_next   = SRC_KEY;
          pend_next  = 1'b1;
          st_ms_next = MS_ZERO;
        end else if (inputs_live && ign_rise) begin
          state_next = ST_SELFTEST;
          src_next   = SRC_IGN;
          pend_next  = 1'b1;
          st_ms_next = MS_ZERO;
        end
      end
      ST_SELFTEST: begin
        st_ms_next = sat_inc(st_ms_reg, tick);
        if (inputs_live && !pend_reg && key_on_pulse) begin
          pend_next = 1'b1;
          src_next  = SRC_KEY;
        end else if (inputs_live && !pend_reg && ign_rise) begin
          pend_next = 1'b1;
          src_next  = SRC_IGN;
        end
        if (st_ms_reg >= MS_W'(SELFTEST_MS)) begin
          on_ms_next  = MS_ZERO;
          key_ok_next = !key_s;
          if (pend_reg || (inputs_live && (key_on_pulse || ign_rise)))
            state_next = ST_ON;
          else
            state_next = ST_SHUTDOWN;
          st_ms_next = MS_ZERO;
        end
      end
      ST_ON: begin
        if (key_ok_reg && key_ms_reg >= MS_W'(KEY_OFF_MS)) begin
          state_next = ST_SHUTDOWN;
          st_ms_next = MS_ZERO;
        end else if (src_reg == SRC_IGN && !ign_s
                     && on_ms_reg >= MS_W'(IGN_GUARD_MS)) begin
          state_next = ST_SHUTDOWN;
          st_ms_next = MS_ZERO;
        end
      end
      ST_SHUTDOWN: begin
        st_ms_next = sat_inc(st_ms_reg, tick);
        if (st_ms_reg >= MS_W'(SHUTDOWN_MS))
          state_next = ST_OFF;
      end
      default: state_next = ST_OFF;
    endcase
    if (!sup_s)
      state_next = ST_OFF;
    off_n_next = (state_next != ST_OFF);
    cts_next   = (state_next != ST_ON);
    rtc_next   = sup_s && state_next == ST_OFF;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg             <= ST_OFF;
      src_reg               <= SRC_NONE;
      st_ms_reg             <= MS_ZERO;
      on_ms_reg             <= MS_ZERO;
      sup_ms_reg            <= MS_ZERO;
      key_ms_reg            <= MS_ZERO;
      sup_prev_reg          <= 1'b0;
      ign_prev_reg          <= 1'b0;
      key_prev_reg          <= 1'b0;
      pend_reg              <= 1'b0;
      key_ok_reg            <= 1'b0;
      powered_off_n         <= 1'b0;
      uart1_clear_to_send_n <= 1'b1;
      uart2_clear_to_send_n <= 1'b1;
      rtc_only              <= 1'b0;
    end else begin
      state_reg             <= state_next;
      src_reg               <= src_next;
      st_ms_reg             <= st_ms_next;
      on_ms_reg             <= on_ms_next;
      sup_ms_reg            <= sup_ms_next;
      key_ms_reg            <= key_ms_next;
      sup_prev_reg          <= sup_prev_next;
      ign_prev_reg          <= ign_prev_next;
      key_prev_reg          <= key_prev_next;
      pend_reg              <= pend_next;
      key_ok_reg            <= key_ok_next;
      powered_off_n         <= off_n_next;
      uart1_clear_to_send_n <= cts_next;
      uart2_clear_to_send_n <= cts_next;
      rtc_only              <= rtc_next;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_off_indicator: assert property (@(posedge clk) disable iff (reset)
    powered_off_n == (state_reg != ST_OFF)) else $error("off indicator mismatch");
  a_cts1_ready: assert property (@(posedge clk) disable iff (reset)
    !uart1_clear_to_send_n |-> state_reg == ST_ON) else $error("uart1 cts early");
  a_cts2_same: assert property (@(posedge clk) disable iff (reset)
    uart2_clear_to_send_n == uart1_clear_to_send_n) else $error("uart2 cts differs");
  a_selftest_len: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_SELFTEST && $past(state_reg) != ST_SELFTEST)
      |-> st_ms_reg == MS_ZERO) else $error("self-test not restarted");
  a_selftest_done: assert property (@(posedge clk) disable iff (reset)
    $rose(state_reg == ST_ON) |-> $past(st_ms_reg) >= MS_W'(SELFTEST_MS))
    else $error("on before self-test end");
  a_rtc_only: assert property (@(posedge clk) disable iff (reset)
    rtc_only |-> !powered_off_n) else $error("rtc flag while on");
  a_auto_off: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_SELFTEST && st_ms_reg >= MS_W'(SELFTEST_MS) && !pend_reg
      && !key_on_pulse && !ign_rise && sup_s) |=> state_reg == ST_SHUTDOWN)
    else $error("no auto power-off");
  a_key_off: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_ON && key_ok_reg && key_ms_reg >= MS_W'(KEY_OFF_MS) && sup_s)
      |=> state_reg == ST_SHUTDOWN) else $error("key off ignored");
  a_ign_guard: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_ON && $past(state_reg) == ST_ON && src_reg == SRC_IGN
      && on_ms_reg < MS_W'(IGN_GUARD_MS) && key_ms_reg < MS_W'(KEY_OFF_MS) && sup_s)
      |=> state_reg == ST_ON) else $error("ignition off inside guard");
  a_ign_src: assert property (@(posedge clk) disable iff (reset)
    (state_reg == ST_ON && src_reg != SRC_IGN && !key_ok_reg && sup_s)
      |=> state_reg == ST_ON) else $error("ignition off without ignition on");
endmodule

// ===== verif/host_model.sv
// Host-side model driving the power key and the ignition line
`timescale 1ns/1ns
module host_model (
  // Host requests
  input  wire logic key_press,
  input  wire logic ign_request,
  // Lines toward the module
  output logic      power_key_n,
  output logic      ignition_in
);
  // ------------------------------------------------------------
  // Line levels
  // ------------------------------------------------------------
  // Key line driven low while pressed and driven high when released
  assign power_key_n = key_press ? 1'h0 : 1'h1;
  // Ignition stays low unless power is wanted
  assign ignition_in = ign_request;
endmodule

// ===== verif/power_sequencer_tb.sv
// Self-checking testbench for the module power sequencer
`timescale 1ns/1ns
module power_sequencer_tb;
  import pwr_seq_pkg::*;

  // Short tick keeps the long timers within a practical run
  localparam int unsigned MS_CYCLES = 2;
  localparam int          LIMIT     = 90000;
  logic clk;
  logic reset;
  logic supply_good;
  logic key_press;
  logic ign_request;
  logic power_key_n;
  logic ignition_in;
  logic powered_off_n;
  logic uart1_clear_to_send_n;
  logic uart2_clear_to_send_n;
  logic rtc_only;
  int   bad_count;
  int   compares;
  int   cycles;

  host_model i_host (
    .key_press   (key_press),
    .ign_request (ign_request),
    .power_key_n (power_key_n),
    .ignition_in (ignition_in)
  );

  power_sequencer #(
    .TICK_DIV (MS_CYCLES)
  ) i_dut (
    .clk                   (clk),
    .reset                 (reset),
    .supply_good           (supply_good),
    .power_key_n           (power_key_n),
    .ignition_in           (ignition_in),
    .powered_off_n         (powered_off_n),
    .uart1_clear_to_send_n (uart1_clear_to_send_n),
    .uart2_clear_to_send_n (uart2_clear_to_send_n),
    .rtc_only              (rtc_only)
  );

  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic wait_ms(input int unsigned n);
    wait_cycles(int'(n * MS_CYCLES));
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_state(input logic off_n, input logic cts_n);
    check_bit("powered_off_n", off_n, powered_off_n);
    check_bit("uart1_clear_to_send_n", cts_n, uart1_clear_to_send_n);
    check_bit("uart2_clear_to_send_n", cts_n, uart2_clear_to_send_n);
  endtask

  task automatic do_reset();
    @(posedge clk);
    reset <= 1'h1;
    wait_cycles(20);
    @(posedge clk);
    reset <= 1'h0;
    wait_cycles(2);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset_state();
    do_reset();
    check_state(1'h0, 1'h1);
    check_bit("rtc_only", 1'h0, rtc_only);
  endtask

  task automatic test_supply_start();
    @(posedge clk);
    supply_good <= 1'h1;
    wait_cycles(8);
    check_state(1'h1, 1'h1);
    check_bit("rtc_only", 1'h0, rtc_only);
  endtask

  task automatic test_early_requests();
    @(posedge clk);
    key_press   <= 1'h1;
    ign_request <= 1'h1;
    wait_ms(INPUT_HOLD_MS / 2);
    @(posedge clk);
    key_press   <= 1'h0;
    ign_request <= 1'h0;
    wait_ms(SELFTEST_MS - 100);
    check_state(1'h1, 1'h1);
    wait_ms(100);
    check_state(1'h0, 1'h1);
    check_bit("rtc_only", 1'h1, rtc_only);
  endtask

  task automatic test_key_on();
    @(posedge clk);
    key_press <= 1'h1;
    wait_ms(KEY_ON_MIN_MS + 200);
    check_state(1'h0, 1'h1);
    @(posedge clk);
    key_press <= 1'h0;
    wait_ms(SELFTEST_MS - 50);
    check_state(1'h1, 1'h1);
    wait_ms(100);
    check_state(1'h1, 1'h0);
    check_bit("rtc_only", 1'h0, rtc_only);
  endtask

  task automatic test_key_off();
    @(posedge clk);
    key_press <= 1'h1;
    wait_ms(KEY_OFF_MS - 50);
    check_state(1'h1, 1'h0);
    wait_ms(100);
    check_state(1'h0, 1'h1);
    @(posedge clk);
    key_press <= 1'h0;
    wait_ms(50);
    check_state(1'h0, 1'h1);
  endtask

  task automatic test_supply_loss();
    check_bit("rtc_only", 1'h1, rtc_only);
    @(posedge clk);
    supply_good <= 1'h0;
    wait_cycles(6);
    check_state(1'h0, 1'h1);
    check_bit("rtc_only", 1'h0, rtc_only);
    @(posedge clk);
    supply_good <= 1'h1;
    wait_cycles(8);
    check_state(1'h1, 1'h1);
    @(posedge clk);
    supply_good <= 1'h0;
    wait_cycles(6);
    check_state(1'h0, 1'h1);
  endtask

  task automatic test_ignition();
    @(posedge clk);
    supply_good <= 1'h0;
    wait_cycles(6);
    check_state(1'h0, 1'h1);
    @(posedge clk);
    supply_good <= 1'h1;
    wait_ms(INPUT_HOLD_MS * 2);
    @(posedge clk);
    ign_request <= 1'h1;
    wait_ms(SELFTEST_MS - 250);
    check_state(1'h1, 1'h1);
    wait_ms(100);
    check_state(1'h1, 1'h0);
    wait_ms(1000);
    @(posedge clk);
    ign_request <= 1'h0;
    wait_ms(1000);
    check_state(1'h1, 1'h0);
    wait_ms(IGN_GUARD_MS - 2150);
    check_state(1'h1, 1'h0);
    wait_ms(150);
    check_state(1'h0, 1'h1);
  endtask

  task automatic test_reset_midrun();
    @(posedge clk);
    supply_good <= 1'h1;
    wait_cycles(8);
    check_state(1'h1, 1'h1);
    do_reset();
    check_state(1'h0, 1'h1);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    reset       = 1'h1;
    supply_good = 1'h0;
    key_press   = 1'h0;
    ign_request = 1'h0;
    bad_count   = 0;
    compares    = 0;
    cycles      = 0;
    test_reset_state();
    test_supply_start();
    test_early_requests();
    test_key_on();
    test_key_off();
    test_supply_loss();
    test_reset_midrun();
    test_ignition();
    end_of_test();
  end
endmodule
